// >>> core/adc_output_port.v
// mode pins, serial programming port and sample output stage of the converter
`timescale 1ns/100ps
`default_nettype none
`include "adc_port_map.vh"
module adc_output_port (
   // clock and reset
   input  wire        mclk,
   input  wire        reset,
   // pins from outside the clock domain
   input  wire        program_mode_strap,
   input  wire        encode_clock_true,
   input  wire        encode_clock_complement,
   input  wire        chip_select_n,
   input  wire        serial_clock,
   input  wire        serial_data_in,
   // open-drain serial data out
   output reg         serial_data_out,
   output reg         serial_data_out_oe,
   // converter core result, same clock domain
   input  wire [13:0] sample_value,
   input  wire        sample_over_range,
   // sample outputs
   output reg  [13:0] data_pins,
   output reg         range_flag,
   output reg         forwarded_output_clock_true,
   output reg         forwarded_output_clock_complement,
   // operating mode status
   output reg  [1:0]  output_mode,
   output reg  [2:0]  lvds_current,
   output reg         lvds_termination,
   output reg         stabilizer_enable,
   output reg         sleep_mode,
   output reg         nap_mode,
   output reg         conversion_start,
   output reg         sample_dropped
);
   // two-flop synchronisers for every pin input
   reg  [5:0] pin_meta_q;
   reg  [5:0] pin_sync_q;
   wire       strap_s;
   wire       enc_t_s;
   wire       enc_c_s;
   wire       cs_n_s;
   wire       sck_s;
   wire       sdi_s;

   always @(posedge mclk) begin
      if (reset) begin
         pin_meta_q <= 6'h00;
         pin_sync_q <= 6'h00;
      end else begin
         pin_meta_q <= {program_mode_strap, encode_clock_true, encode_clock_complement,
                        chip_select_n, serial_clock, serial_data_in};
         pin_sync_q <= pin_meta_q;
      end
   end
   assign strap_s = pin_sync_q[5];
   assign enc_t_s = pin_sync_q[4];
   assign enc_c_s = pin_sync_q[3];
   assign cs_n_s  = pin_sync_q[2];
   assign sck_s   = pin_sync_q[1];
   assign sdi_s   = pin_sync_q[0];

   // edge detection on synchronised levels
   reg  sck_q;
   reg  enc_q;
   wire enc_lvl;
   wire sck_rise;
   wire sck_fall;
   wire enc_rise;
   wire enc_fall;
   wire serial_mode;
   wire framed;

   // true high with complement low; a grounded complement leaves the true input alone
   assign enc_lvl  = enc_t_s & ~enc_c_s;
   assign enc_rise = enc_lvl & ~enc_q;
   assign enc_fall = ~enc_lvl & enc_q;
   assign sck_rise = sck_s & ~sck_q;
   assign sck_fall = ~sck_s & sck_q;
   // strap low selects the serial port; the strap is assumed static
   assign serial_mode = ~strap_s;
   // shifting only inside a low chip select
   assign framed = serial_mode & ~cs_n_s;

   always @(posedge mclk) begin
      if (reset) begin
         sck_q <= 1'b0;
         enc_q <= 1'b0;
      end else begin
         sck_q <= sck_s;
         enc_q <= enc_lvl;
      end
   end

   // serial frame: command bit, address, data; mode registers
   reg  [14:0] shift_q;
   reg  [4:0]  bitcnt_q;
   reg  [7:0]  rd_shift_q;
   reg         rd_frame_q;
   reg  [7:0]  power_q;
   reg  [7:0]  timing_q;
   reg  [7:0]  output_q;
   wire [7:0]  wr_data;
   wire [6:0]  wr_addr;
   wire        wr_fire;
   wire        soft_reset;

   // readback decode, used at the header boundary
   function [7:0] reg_read;
      input [6:0] addr;
      input [7:0] pw;
      input [7:0] tm;
      input [7:0] om;
      begin
         case (addr)
            `REG_POWER:  reg_read = pw;
            `REG_TIMING: reg_read = tm;
            `REG_OUTPUT: reg_read = om;
            default:     reg_read = 8'h00;
         endcase
      end
   endfunction

   assign wr_data    = {shift_q[6:0], sdi_s};
   assign wr_addr    = shift_q[13:7];
   assign wr_fire    = framed & sck_rise & (bitcnt_q == (`FRAME_BITS - 5'h01)) & ~shift_q[14];
   assign soft_reset = wr_fire & (wr_addr == `REG_RESET) & wr_data[`RESET_BIT];

   // sample data in on each rising serial clock inside the frame
   always @(posedge mclk) begin
      if (reset) begin
         shift_q  <= 15'h0000;
         bitcnt_q <= 5'h00;
      end else if (~framed) begin
         bitcnt_q <= 5'h00;
      end else if (sck_rise) begin
         shift_q <= {shift_q[13:0], sdi_s};
         if (bitcnt_q != `FRAME_BITS) begin
            bitcnt_q <= bitcnt_q + 5'h01;
         end
      end
   end

   // mode register writes; a reset write returns them to defaults
   always @(posedge mclk) begin
      if (reset | soft_reset) begin
         power_q  <= `POWER_RST;
         timing_q <= `TIMING_RST;
         output_q <= `OUTPUT_RST;
      end else if (wr_fire) begin
         case (wr_addr)
            `REG_POWER:  power_q  <= wr_data;
            `REG_TIMING: timing_q <= wr_data;
            `REG_OUTPUT: output_q <= wr_data;
            default:     power_q  <= power_q;
         endcase
      end
   end

   // readback: loaded after the header, one bit per falling serial clock
   always @(posedge mclk) begin
      if (reset) begin
         rd_shift_q         <= 8'h00;
         rd_frame_q         <= 1'b0;
         serial_data_out    <= 1'b0;
         serial_data_out_oe <= 1'b0;
      end else if (~framed) begin
         // released outside a frame and in parallel mode
         rd_frame_q         <= 1'b0;
         serial_data_out_oe <= 1'b0;
      end else if (sck_rise & (bitcnt_q == (`HDR_BITS - 5'h01))) begin
         rd_frame_q <= shift_q[6];
         rd_shift_q <= reg_read({shift_q[5:0], sdi_s}, power_q, timing_q, output_q);
      end else if (sck_fall & (bitcnt_q >= `HDR_BITS) & (bitcnt_q < `FRAME_BITS) &
                   rd_frame_q) begin
         // pull low for a zero, release for a one
         serial_data_out_oe <= ~rd_shift_q[7];
         rd_shift_q         <= {rd_shift_q[6:0], 1'b0};
      end else if (sck_fall & (bitcnt_q == `FRAME_BITS)) begin
         serial_data_out_oe <= 1'b0;
      end
   end

   // effective modes from registers or from static parallel pins
   reg  [1:0] mode_d;
   reg  [2:0] cur_d;
   reg        term_d;
   reg        dcs_d;
   reg        sleep_d;
   reg        nap_d;
   reg  [1:0] phase_d;

   always @* begin
      if (serial_mode) begin
         mode_d  = output_q[`OUT_MODE_HI:`OUT_MODE_LO];
         cur_d   = output_q[`OUT_CUR_HI:`OUT_CUR_LO];
         term_d  = output_q[`OUT_TERM];
         dcs_d   = timing_q[`TIMING_DCS];
         sleep_d = power_q[`POWER_SLEEP];
         nap_d   = power_q[`POWER_NAP];
         // output clock delay comes from the timing register
         phase_d = timing_q[`TIMING_PH_HI:`TIMING_PH_LO];
      end else begin
         // static pins give a reduced set of modes
         // clock pin picks full-rate CMOS or high-current LVDS
         mode_d  = sck_s ? `MODE_DDR_LVDS : `MODE_CMOS;
         cur_d   = `CUR_HIGH;
         term_d  = 1'b0;
         // chip select level drives the stabilizer
         dcs_d   = cs_n_s;
         // data in high puts the part to sleep
         sleep_d = sdi_s;
         nap_d   = 1'b0;
         phase_d = 2'h0;
      end
   end

   // mode status, drive current and termination reported to the pad ring
   always @(posedge mclk) begin
      if (reset) begin
         output_mode       <= `MODE_CMOS;
         lvds_current      <= 3'h0;
         lvds_termination  <= 1'b0;
         stabilizer_enable <= 1'b0;
         sleep_mode        <= 1'b0;
         nap_mode          <= 1'b0;
      end else begin
         output_mode       <= mode_d;
         lvds_current      <= cur_d;
         lvds_termination  <= term_d & (mode_d == `MODE_DDR_LVDS);
         stabilizer_enable <= dcs_d;
         sleep_mode        <= sleep_d;
         nap_mode          <= nap_d;
      end
   end

   // sample buffer between the converter core and the pins
   wire        powered;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [14:0] fifo_out_data;
   wire        take;

   assign powered = ~(sleep_mode | nap_mode);
   // a powered-down output stage stops draining, so in nap the buffer really fills; sleep also stops the filling
   assign take    = enc_fall & powered & fifo_out_valid;

   sample_fifo #(
      .W  (`SAMPLE_W),
      .D  (`FIFO_DEPTH),
      .AW (4)
   ) u_fifo (
      .mclk      (mclk),
      .reset     (reset),
      .in_valid  (enc_rise & ~sleep_mode),
      .in_ready  (fifo_in_ready),
      .in_data   ({sample_over_range, sample_value}),
      .out_valid (fifo_out_valid),
      .out_ready (take),
      .out_data  (fifo_out_data)
   );

   // one conversion per encode rise outside sleep; a full buffer drops it and says so
   always @(posedge mclk) begin
      if (reset) begin
         conversion_start <= 1'b0;
         sample_dropped   <= 1'b0;
      end else begin
         conversion_start <= enc_rise & ~sleep_mode;
         sample_dropped   <= enc_rise & ~sleep_mode & ~fifo_in_ready;
      end
   end

   // output stage: held word, lane mux and forwarded clock
   reg  [13:0] hold_q;
   reg  [2:0]  enc_dly_q;
   reg  [13:0] ddr_pins;
   wire        ddr;
   wire        clk_next;

   assign ddr = (mode_d != `MODE_CMOS);

   // seven lanes carry bit pairs; the even pins are left unused
   // even bit on the falling edge, odd bit on the rising edge
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : g_lane
         always @* begin
            ddr_pins[2*g]   = 1'b0;
            ddr_pins[2*g+1] = enc_fall ? fifo_out_data[2*g] : hold_q[2*g+1];
         end
      end
   endgenerate

   // true output clock lags the encode level by one to four cycles
   assign clk_next = (phase_d == 2'h0) ? enc_lvl : enc_dly_q[phase_d - 2'h1];

   always @(posedge mclk) begin
      if (reset) begin
         enc_dly_q <= 3'h0;
         forwarded_output_clock_true       <= 1'b0;
         forwarded_output_clock_complement <= 1'b1;
      end else begin
         enc_dly_q <= {enc_dly_q[1:0], enc_lvl};
         // powered-down stage parks its clock low, so no phantom words are seen
         forwarded_output_clock_true       <= clk_next & powered;
         forwarded_output_clock_complement <= ~(clk_next & powered);
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         hold_q     <= 14'h0000;
         data_pins  <= 14'h0000;
         range_flag <= 1'b0;
      end else if (take) begin
         hold_q     <= fifo_out_data[13:0];
         // range flag travels with its own sample
         range_flag <= fifo_out_data[14];
         if (ddr) begin
            data_pins <= ddr_pins;
         end else begin
            // full word on the falling edge, bit 13 most significant
            data_pins <= fifo_out_data[13:0];
         end
      end else if (enc_rise & ddr & powered) begin
         // rising edge update with the odd bits
         data_pins <= ddr_pins;
      end
   end
endmodule // adc_output_port
`default_nettype wire

// >>> core/adc_port_map.vh
// offsets, field positions, reset values and timing counts for the converter output port
`ifndef ADC_PORT_MAP_VH
`define ADC_PORT_MAP_VH
// mode register addresses
`define REG_RESET       7'h00
`define REG_POWER       7'h01
`define REG_TIMING      7'h02
`define REG_OUTPUT      7'h03
// field positions
`define RESET_BIT       7
`define POWER_SLEEP     0
`define POWER_NAP       1
`define TIMING_DCS      0
`define TIMING_PH_LO    1
`define TIMING_PH_HI    2
`define OUT_MODE_LO     0
`define OUT_MODE_HI     1
`define OUT_TERM        4
`define OUT_CUR_LO      5
`define OUT_CUR_HI      7
// reset values
`define POWER_RST       8'h00
`define TIMING_RST      8'h00
`define OUTPUT_RST      8'h00
// output mode codes
`define MODE_CMOS       2'h0
`define MODE_DDR_CMOS   2'h1
`define MODE_DDR_LVDS   2'h2
// lvds drive code used by parallel mode (higher current)
`define CUR_HIGH        3'h0
// serial frame: one command bit, seven address bits, eight data bits
`define FRAME_BITS      5'h10
`define HDR_BITS        5'h08
// sample word: fourteen data bits plus range flag
`define SAMPLE_W        15
`define FIFO_DEPTH      16
`define PHASE_MAX       3
`endif

// >>> core/sample_fifo.v
// parameterised first-in first-out buffer for converted samples
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
   parameter W  = 15,
   parameter D  = 16,
   parameter AW = 4
) (
   // clock and reset
   input  wire         mclk,
   input  wire         reset,
   // filling side
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   // draining side
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg  [W-1:0] mem [0:D-1];
   reg  [AW-1:0] wr_q;
   reg  [AW-1:0] rd_q;
   reg  [AW:0]   cnt_q;
   wire          push;
   wire          pop;

   // honest flags straight from the occupancy count
   assign in_ready  = (cnt_q != D[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage has no reset; only pointers and count need a defined value
   always @(posedge mclk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers and count
   always @(posedge mclk) begin
      if (reset) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // sample_fifo
`default_nettype wire

// >>> verif/adc_port_checker_asserts.sv
// concurrent checks on the converter output port pins
`timescale 1ns/100ps
`default_nettype none
module adc_port_checker (
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset,
   // mode pins
   input wire logic        program_mode_strap,
   input wire logic        chip_select_n,
   input wire logic        serial_clock,
   input wire logic        serial_data_in,
   // serial data out
   input wire logic        serial_data_out,
   input wire logic        serial_data_out_oe,
   // sample outputs and status
   input wire logic [13:0] data_pins,
   input wire logic        forwarded_output_clock_true,
   input wire logic        forwarded_output_clock_complement,
   input wire logic [1:0]  output_mode,
   input wire logic [2:0]  lvds_current,
   input wire logic        lvds_termination,
   input wire logic        stabilizer_enable,
   input wire logic        sleep_mode,
   input wire logic        conversion_start,
   input wire logic        sample_dropped
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // pin levels pass synchronisers, so static modes get eight cycles to settle
   a_clk_inverse: assert property (forwarded_output_clock_complement == !forwarded_output_clock_true)
      else $error("output clock pair not inverse");
   a_sdo_open_drain: assert property (serial_data_out == 1'b0)
      else $error("data out drives high");
   a_sdo_release: assert property ((chip_select_n || program_mode_strap) [*8] |-> !serial_data_out_oe)
      else $error("data out pulled outside a frame");
   a_start_pulse: assert property (conversion_start |=> !conversion_start)
      else $error("conversion start longer than one cycle");
   a_par_stab_on: assert property ((program_mode_strap && chip_select_n) [*8] |-> stabilizer_enable)
      else $error("stabilizer off with select high");
   a_par_stab_off: assert property ((program_mode_strap && !chip_select_n) [*8] |-> !stabilizer_enable)
      else $error("stabilizer on with select low");
   a_par_lvds: assert property ((program_mode_strap && serial_clock) [*8]
      |-> output_mode == 2'h2 && lvds_current == 3'h0)
      else $error("parallel lvds mode wrong");
   a_par_cmos: assert property ((program_mode_strap && !serial_clock) [*8] |-> output_mode == 2'h0)
      else $error("parallel cmos mode wrong");
   a_par_sleep: assert property ((program_mode_strap && serial_data_in) [*8] |-> sleep_mode)
      else $error("sleep not entered");
   a_par_awake: assert property ((program_mode_strap && !serial_data_in) [*8] |-> !sleep_mode)
      else $error("sleep without request");
   // output mode held three cycles so a reformat on a mode change is excused
   a_cmos_fall: assert property (output_mode == 2'h0 && $past(output_mode, 3) == 2'h0
      && $changed(data_pins) |-> $fell(forwarded_output_clock_true))
      else $error("cmos data moved off the clock fall");
   a_ddr_edges: assert property (output_mode != 2'h0 && $past(output_mode, 3) == output_mode
      && $changed(data_pins) |-> $changed(forwarded_output_clock_true))
      else $error("ddr data moved off a clock edge");
   a_ddr_lanes: assert property (output_mode != 2'h0 && $changed(data_pins)
      |-> (data_pins & 14'h1555) == 14'h0000)
      else $error("ddr even pins not idle");
   a_term_lvds: assert property (lvds_termination |-> output_mode == 2'h2)
      else $error("termination outside lvds");
   a_drop_pulse: assert property (sample_dropped |=> !sample_dropped)
      else $error("drop pulse too long");
   c_convert: cover property (conversion_start);
   c_dropped: cover property (sample_dropped);
   c_readback: cover property (serial_data_out_oe);
   c_lvds: cover property (output_mode == 2'h2 && $changed(data_pins));
endmodule // adc_port_checker
bind adc_output_port adc_port_checker i_chk (.mclk, .reset, .program_mode_strap, .chip_select_n,
   .serial_clock, .serial_data_in, .serial_data_out, .serial_data_out_oe, .data_pins,
   .forwarded_output_clock_true, .forwarded_output_clock_complement, .output_mode,
   .lvds_current, .lvds_termination, .stabilizer_enable, .sleep_mode, .conversion_start,
   .sample_dropped);
`default_nettype wire

// >>> verif/capture_rx.sv
// capture model that rebuilds sample words from the forwarded stream
`timescale 1ns/100ps
`default_nettype none
module capture_rx (
   // clock
   input  wire logic        mclk,
   // forwarded stream
   input  wire logic [13:0] data_pins,
   input  wire logic        range_flag,
   input  wire logic        forwarded_output_clock_true,
   input  wire logic [1:0]  output_mode,
   // rebuilt word
   output var  logic        rx_valid,
   output var  logic [14:0] rx_word
);
   logic        prev_q;
   logic        even_ok = 1'b0;
   logic [13:0] even_q;
   logic [13:0] w;
   // lane i sits on pin 2i+1; even half from the fall, odd half at the rise
   always @* begin
      for (int i = 0; i < 7; i++) begin
         w[2*i]   = even_q[2*i+1];
         w[2*i+1] = data_pins[2*i+1];
      end
   end
   // edges found by sampling; a half word seen before a change to full-rate mode is not paired
   always @(posedge mclk) begin
      prev_q   <= forwarded_output_clock_true;
      rx_valid <= 1'b0;
      // a full-rate spell, reset included, drops any half word left waiting
      if (output_mode == 2'h0) begin
         even_ok <= 1'b0;
      end
      // word and flag taken with the clock
      if (prev_q && !forwarded_output_clock_true) begin
         even_q  <= data_pins;
         even_ok <= (output_mode != 2'h0);
         if (output_mode == 2'h0) begin
            rx_valid <= 1'b1;
            rx_word  <= {range_flag, data_pins};
         end
      end
      // odd bits join at the rise
      if (!prev_q && forwarded_output_clock_true && even_ok && output_mode != 2'h0) begin
         rx_valid <= 1'b1;
         rx_word  <= {range_flag, w};
         even_ok  <= 1'b0;
      end
   end
endmodule // capture_rx
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the converter output port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic mclk = 0, reset = 1, program_mode_strap = 0, encode_clock_true = 0;
   logic encode_clock_complement = 0, chip_select_n = 1, serial_clock = 0, serial_data_in = 0;
   logic [13:0] sample_value = 14'h0000;
   logic sample_over_range = 0, serial_data_out, serial_data_out_oe, range_flag;
   logic forwarded_output_clock_true, forwarded_output_clock_complement, lvds_termination;
   logic stabilizer_enable, sleep_mode, nap_mode, conversion_start, sample_dropped, rx_valid;
   logic [13:0] data_pins;
   logic [1:0] output_mode;
   logic [2:0] lvds_current;
   logic [14:0] rx_word, ew;
   logic [15:0] lfsr = 16'd5481;
   logic [7:0] r;
   logic enc_run = 0, diff = 0, nap_x = 0, sleep_x = 0;
   int fails = 0, n_checks = 0, cyc = 0, ediv = 0, cnt = 0, n_rise = 0;
   int drops_x = 0, n_drop = 0, n_conv = 0, c0, nc0 = 0;
   logic [14:0] expq[$];
   // pull-up on the open-drain line, left unread in parallel mode
   wire logic sdo_line = serial_data_out_oe ? serial_data_out : 1'b1;
   always #20 mclk = ~mclk;
   adc_output_port i_dut (.mclk, .reset, .program_mode_strap, .encode_clock_true,
      .encode_clock_complement, .chip_select_n, .serial_clock, .serial_data_in,
      .serial_data_out, .serial_data_out_oe, .sample_value, .sample_over_range, .data_pins,
      .range_flag, .forwarded_output_clock_true, .forwarded_output_clock_complement,
      .output_mode, .lvds_current, .lvds_termination, .stabilizer_enable, .sleep_mode,
      .nap_mode, .conversion_start, .sample_dropped);
   capture_rx i_rx (.mclk, .data_pins, .range_flag, .forwarded_output_clock_true,
      .output_mode, .rx_valid, .rx_word);
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task results;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one serial frame of n bits; readback taken just before each late fall
   task automatic frame(input logic [15:0] w, input int n, input bit sel,
                        output logic [7:0] rb);
      rb = 8'h00;
      chip_select_n = !sel;
      repeat (4) @(negedge mclk);
      for (int i = 15; i > 15 - n; i--) begin
         // data set up well before the rise
         serial_data_in = w[i];
         repeat (4) @(negedge mclk);
         serial_clock = 1;
         repeat (4) @(negedge mclk);
         // readback bit taken before the fall
         if (i < 8) rb[i] = sdo_line;
         serial_clock = 0;
      end
      repeat (4) @(negedge mclk);
      chip_select_n = 1;
      repeat (8) @(negedge mclk);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      frame({1'b0, a, d}, 16, 1, r);
   endtask
   task automatic rd(input logic [6:0] a);
      frame({1'b1, a, 8'h00}, 16, 1, r);
   endtask
   // encode runs n rises, then parks low; in a double-rate mode the last word's odd half waits for the next rise
   task automatic run(input int n);
      c0 = n_rise + n;
      enc_run = 1;
      while (n_rise < c0) @(negedge mclk);
      enc_run = 0;
      repeat (24) @(negedge mclk);
   endtask
   // encode clock at 320 ns with corner samples first; expected queue follows the rules
   always @(negedge mclk) begin
      if (enc_run || encode_clock_true) begin
         if (ediv == 3) begin
            ediv = 0;
            encode_clock_true = !encode_clock_true;
            if (encode_clock_true) begin
               lfsr = nxt(lfsr);
               {sample_over_range, sample_value} = (n_rise == 0) ? 15'h7fff :
                  (n_rise == 1) ? 15'h0000 : {lfsr[15], lfsr[13:0]};
               n_rise++;
               if (!sleep_x && cnt == 16) drops_x++;
               else if (!sleep_x) begin
                  expq.push_back({sample_over_range, sample_value});
                  cnt++;
               end
            end else if (!sleep_x && !nap_x && cnt > 0) cnt--;
         end else ediv++;
      end
      encode_clock_complement = diff ? !encode_clock_true : 1'b0;
   end
   // pulse counts, word checks and the hang limit
   always @(negedge mclk) begin
      n_conv += conversion_start;
      n_drop += sample_dropped;
      if (rx_valid && expq.size() == 0) begin
         fails++;
         $display("[FAIL] rx_word exp none got %h", rx_word);
      end else if (rx_valid) begin
         ew = expq.pop_front();
         `CHK("rx_word", ew, rx_word)
      end
      if (++cyc == 40000) begin
         fails++;
         results();
      end
   end
   initial begin
      repeat (5) @(negedge mclk);
      reset = 0;
      repeat (4) @(negedge mclk);
      for (int a = 0; a < 4; a++) begin
         rd(a[6:0]);
         `CHK("reg_reset", 8'h00, r)
      end
      wr(7'h03, 8'hb2);
      rd(7'h03);
      `CHK("readback", 8'hb2, r)
      `CHK("lvds_cfg", {2'h2, 3'h5, 1'b1}, {output_mode, lvds_current, lvds_termination})
      wr(7'h02, 8'h01);
      `CHK("stab_reg", 1'b1, stabilizer_enable)
      wr(7'h55, 8'hff);
      rd(7'h55);
      `CHK("unmapped", 8'h00, r)
      frame(16'h0301, 16, 0, r);
      `CHK("cs_high", 2'h2, output_mode)
      frame(16'h0301, 8, 1, r);
      `CHK("short", 2'h2, output_mode)
      wr(7'h00, 8'h80);
      `CHK("soft_mode", 2'h0, output_mode)
      `CHK("soft_stab", 1'b0, stabilizer_enable)
      wr(7'h03, 8'h00);
      run(20);
      // nap stalls the drain: sixteen words fit, the rest are dropped
      wr(7'h01, 8'h02);
      nap_x = 1;
      nc0 = n_conv;
      run(18);
      `CHK("drops", drops_x, n_drop)
      `CHK("nap_conv", nc0 + 18, n_conv)
      wr(7'h01, 8'h00);
      nap_x = 0;
      run(24);
      for (int m = 1; m < 3; m++) begin
         wr(7'h03, m[7:0]);
         run(20);
      end
      // second reset into parallel mode with a differential encode
      // strap moved only while reset holds
      reset = 1;
      program_mode_strap = 1;
      diff = 1;
      expq.delete();
      cnt = 0;
      repeat (5) @(negedge mclk);
      reset = 0;
      for (int k = 0; k < 8; k++) begin
         {chip_select_n, serial_clock, serial_data_in} = k[2:0];
         repeat (8) @(negedge mclk);
         `CHK("par_stab", k[2], stabilizer_enable)
         `CHK("par_mode", k[1] ? 2'h2 : 2'h0, output_mode)
         `CHK("par_sleep", k[0], sleep_mode)
      end
      {chip_select_n, serial_clock, serial_data_in} = 3'b110;
      repeat (8) @(negedge mclk);
      run(20);
      serial_data_in = 1;
      sleep_x = 1;
      repeat (8) @(negedge mclk);
      nc0 = n_conv;
      run(6);
      `CHK("asleep", nc0, n_conv)
      results();
   end
endmodule // tb_top
`default_nettype wire
